// ==== rtl/unbg_pkg.sv ====
// Constants for the nine-bit serial port and its bit rate sources
package unbg_pkg;
    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_SERIAL_CONTROL_REG  = 8'h00;
    localparam logic [7:0] OFS_SERIAL_DATA_BUFFER  = 8'h04;
    localparam logic [7:0] OFS_POWER_CONTROL_REG  = 8'h08;
    localparam logic [7:0] OFS_TIMER2_CONTROL_REG = 8'h0C;
    localparam logic [7:0] OFS_T1    = 8'h10;
    localparam logic [7:0] OFS_T2RLD = 8'h14;
    localparam logic [7:0] OFS_T2CNT = 8'h18;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int B_TXDONE  = 0;
    localparam int B_RXFULL  = 1;
    localparam int B_RXNINTH = 2;
    localparam int B_TXNINTH = 3;
    localparam int B_RXEN    = 4;
    localparam int B_MPF     = 5;
    localparam int B_MODE3   = 6;
    localparam int B_BDOUBLE = 7;
    localparam int B_T2RUN   = 2;
    localparam int B_TXSEL2  = 4;
    localparam int B_RXSEL2  = 5;
    localparam int B_T2OVF   = 7;
    localparam int B_T1RUN   = 16;
    // ----------------------------------------------------------------
    // Reset values and counts
    // ----------------------------------------------------------------
    localparam logic [8:0]  RX_PRELOAD  = 9'h1FF;
    localparam logic [15:0] T2_RST      = 16'h0000;
    localparam logic [7:0]  T1_RST      = 8'h00;
    localparam logic [3:0]  T1_PRESCALE = 4'hB;
    localparam logic [3:0]  DIV16_LAST  = 4'hF;
    localparam logic [3:0]  SMP_A       = 4'h7;
    localparam logic [3:0]  SMP_B       = 4'h8;
    localparam logic [3:0]  SMP_C       = 4'h9;
    localparam logic [1:0]  FIX_LAST    = 2'h3;
endpackage

// ==== rtl/unbg_top.sv ====
// Nine-bit serial port, modes 2 and 3, with bit rate generators
//------------------------------------------------------------------
// Function
// (RULE1) Frame: start, 8 data LSB first, ninth, stop
// (RULE2) Mode 3 differs only by timer rate
// (RULE3) Ninth bit from tx_ninth, into rx_ninth
// (RULE4) Buffer write loads ninth, requests transfer; code ignores the write while tx_req_r or tx_send_r is set
// (RULE5) Transmit starts after next divide-by-16 rollover
// (RULE6) Start bit, then data, then first shift
// (RULE7) First shift inserts stop, then zeros
// (RULE8) Final shift sets done at rollover 11
// (RULE9) Receive starts on falling input edge
// (RULE10) Edge preloads 1FFh, clears divide-by-16
// (RULE11) Majority of samples at states 7-9
// (RULE12) Nonzero start bit aborts, hunt again
// (RULE13) Bits enter right, final shift on start
// (RULE14) Store only if free and filter passes
// (RULE15) Hunt again one bit time later
// (RULE16) Mode 2 rate: osc times 2^double / 64
// (RULE17) Timer 1 rate: 2^double times ovf / 32
// (RULE18) Software sets timer 1 8-bit reload
// (RULE19) Software sets both timer 2 selects
// (RULE20) Timer 2 counts osc/2, 16-bit reload
// (RULE21) Timer 2 baud rollover sets no flag
// (RULE22) Software leaves timer 2 registers alone
//------------------------------------------------------------------
`timescale 1ns/1ns
module unbg_top #(
    parameter int AW = 8
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          rxd,
    output logic               txd
);
    import unbg_pkg::*;

    function automatic logic hit(input logic [AW-1:0] a,
                                 input logic [7:0] o);
        hit = (a == AW'(o));
    endfunction

    function automatic logic maj3(input logic a, input logic b,
                                  input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction

    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++) rev8[i] = v[7-i];
    endfunction

    //--------------------------------------------------------------
    // Register bus
    //--------------------------------------------------------------
    logic        wr_en, rd_setup, mapped;
    logic        tx_done_r, rx_full_r, rx_ninth_r, tx_ninth_r;
    logic        rx_en_r, mpf_r, mode3_r, bdouble_r;
    logic        t2run_r, txsel2_r, rxsel2_r, t2ovf_flag_r, t1run_r;
    logic [7:0]  rx_buf_r, t1_reload_r, t1_cnt_r;
    logic [15:0] t2_reload_r, t2_cnt_r;
    logic [31:0] prdata_r, rd_nxt;

    assign mapped = hit(paddr, OFS_SERIAL_CONTROL_REG) | hit(paddr, OFS_SERIAL_DATA_BUFFER)
                  | hit(paddr, OFS_POWER_CONTROL_REG) | hit(paddr, OFS_TIMER2_CONTROL_REG)
                  | hit(paddr, OFS_T1) | hit(paddr, OFS_T2RLD)
                  | hit(paddr, OFS_T2CNT);
    assign wr_en    = psel & penable & pwrite & mapped;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~mapped;
    assign prdata   = prdata_r;

    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (hit(paddr, OFS_SERIAL_CONTROL_REG)) begin
            rd_nxt[B_TXDONE]  = tx_done_r;
            rd_nxt[B_RXFULL]  = rx_full_r;
            rd_nxt[B_RXNINTH] = rx_ninth_r;
            rd_nxt[B_TXNINTH] = tx_ninth_r;
            rd_nxt[B_RXEN]    = rx_en_r;
            rd_nxt[B_MPF]     = mpf_r;
            rd_nxt[B_MODE3]   = mode3_r;
        end
        if (hit(paddr, OFS_SERIAL_DATA_BUFFER))
            rd_nxt[7:0] = rx_buf_r;
        if (hit(paddr, OFS_POWER_CONTROL_REG))
            rd_nxt[B_BDOUBLE] = bdouble_r;
        if (hit(paddr, OFS_TIMER2_CONTROL_REG)) begin
            rd_nxt[B_T2RUN]  = t2run_r;
            rd_nxt[B_TXSEL2] = txsel2_r;
            rd_nxt[B_RXSEL2] = rxsel2_r;
            rd_nxt[B_T2OVF]  = t2ovf_flag_r;
        end
        if (hit(paddr, OFS_T1))
            rd_nxt[16:0] = {t1run_r, t1_cnt_r, t1_reload_r};
        if (hit(paddr, OFS_T2RLD))
            rd_nxt[15:0] = t2_reload_r;
        if (hit(paddr, OFS_T2CNT))
            rd_nxt[15:0] = t2_cnt_r;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata_r <= 32'h0000_0000;
        else if (rd_setup)
            prdata_r <= rd_nxt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ninth_r  <= 1'b0;
            rx_en_r     <= 1'b0;
            mpf_r       <= 1'b0;
            mode3_r     <= 1'b0;
            bdouble_r   <= 1'b0;
            t2run_r     <= 1'b0;
            txsel2_r    <= 1'b0;
            rxsel2_r    <= 1'b0;
            t1run_r     <= 1'b0;
            t1_reload_r <= T1_RST;
            t2_reload_r <= T2_RST;
        end else if (wr_en) begin
            if (hit(paddr, OFS_SERIAL_CONTROL_REG)) begin
                tx_ninth_r <= pwdata[B_TXNINTH];
                rx_en_r    <= pwdata[B_RXEN];
                mpf_r      <= pwdata[B_MPF];
                mode3_r    <= pwdata[B_MODE3];
            end
            if (hit(paddr, OFS_POWER_CONTROL_REG))
                bdouble_r <= pwdata[B_BDOUBLE];
            if (hit(paddr, OFS_TIMER2_CONTROL_REG)) begin
                t2run_r  <= pwdata[B_T2RUN];
                txsel2_r <= pwdata[B_TXSEL2];
                rxsel2_r <= pwdata[B_RXSEL2];
            end
            if (hit(paddr, OFS_T1)) begin
                t1_reload_r <= pwdata[7:0];
                t1run_r     <= pwdata[B_T1RUN];
            end
            if (hit(paddr, OFS_T2RLD))
                t2_reload_r <= pwdata[15:0];
        end
    end

    //--------------------------------------------------------------
    // Bit rate sources
    //--------------------------------------------------------------
    logic [1:0] fix_cnt_r;
    logic [3:0] pre_cnt_r;
    logic       osc2_r, t1_half_r, t1_ovf, t2_ovf, t2_baud;
    logic       fix_tick, t1_tick, tx_tick, rx_tick;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fix_cnt_r <= 2'h0;
            pre_cnt_r <= 4'h0;
            osc2_r    <= 1'b0;
        end else begin
            fix_cnt_r <= fix_cnt_r + 2'h1;
            pre_cnt_r <= (pre_cnt_r == T1_PRESCALE) ? 4'h0
                                                    : pre_cnt_r + 4'h1;
            osc2_r    <= ~osc2_r;
        end
    end

    // Sixteen times the mode 2 bit rate
    assign fix_tick = bdouble_r ? fix_cnt_r[0]
                                : (fix_cnt_r == FIX_LAST); // RULE16

    assign t1_ovf = t1run_r && (pre_cnt_r == T1_PRESCALE)
                 && (t1_cnt_r == 8'hFF);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t1_cnt_r  <= T1_RST;
            t1_half_r <= 1'b0;
        end else if (wr_en && hit(paddr, OFS_T1)) begin
            t1_cnt_r  <= pwdata[7:0];
        end else if (t1run_r && pre_cnt_r == T1_PRESCALE) begin
            t1_cnt_r  <= t1_ovf ? t1_reload_r : t1_cnt_r + 8'h01;
            t1_half_r <= t1_half_r ^ t1_ovf;
        end
    end
    // Halve the overflow rate unless doubled
    assign t1_tick = t1_ovf & (bdouble_r | t1_half_r); // RULE17

    assign t2_baud = txsel2_r | rxsel2_r;
    assign t2_ovf  = t2run_r && osc2_r && (t2_cnt_r == 16'hFFFF);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            t2_cnt_r <= T2_RST;
        else if (wr_en && hit(paddr, OFS_T2RLD))
            t2_cnt_r <= pwdata[15:0];
        else if (t2run_r && osc2_r)
            t2_cnt_r <= t2_ovf ? t2_reload_r
                               : t2_cnt_r + 16'h0001; // RULE20
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            t2ovf_flag_r <= 1'b0;
        else if (t2_ovf && !t2_baud)
            t2ovf_flag_r <= 1'b1; // RULE21
        else if (wr_en && hit(paddr, OFS_TIMER2_CONTROL_REG))
            t2ovf_flag_r <= pwdata[B_T2OVF];
    end

    assign tx_tick = !mode3_r ? fix_tick
                   : (txsel2_r ? t2_ovf : t1_tick); // RULE2
    assign rx_tick = !mode3_r ? fix_tick
                   : (rxsel2_r ? t2_ovf : t1_tick); // RULE2

    //--------------------------------------------------------------
    // Transmitter
    //--------------------------------------------------------------
    logic [8:0] tx_sr_r;
    logic [3:0] tx_cnt_r;
    logic       tx_req_r, tx_send_r, tx_den_r, tx_first_r;
    logic       tx_roll, serial_data_buffer_wr, tx_last, tx_fin;

    assign serial_data_buffer_wr = wr_en && hit(paddr, OFS_SERIAL_DATA_BUFFER)
                  && !tx_req_r && !tx_send_r;
    assign tx_roll = tx_tick && (tx_cnt_r == DIV16_LAST);
    assign tx_last = !tx_first_r && (tx_sr_r[8:2] == 7'h00)
                  && tx_sr_r[1];
    assign tx_fin  = tx_roll && tx_send_r && tx_den_r && tx_last;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            tx_cnt_r <= 4'h0;
        else if (tx_tick)
            tx_cnt_r <= tx_cnt_r + 4'h1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_sr_r    <= 9'h1FF;
            tx_req_r   <= 1'b0;
            tx_send_r  <= 1'b0;
            tx_den_r   <= 1'b0;
            tx_first_r <= 1'b0;
        end else if (serial_data_buffer_wr) begin
            tx_sr_r  <= {tx_ninth_r, pwdata[7:0]}; // RULE3
            tx_req_r <= 1'b1; // RULE4
        end else if (tx_roll) begin
            if (tx_req_r) begin
                tx_req_r  <= 1'b0;
                tx_send_r <= 1'b1; // RULE5
                tx_den_r  <= 1'b0;
            end else if (tx_send_r && !tx_den_r) begin
                tx_den_r   <= 1'b1; // RULE6
                tx_first_r <= 1'b1;
            end else if (tx_send_r) begin
                tx_sr_r    <= {tx_first_r, tx_sr_r[8:1]}; // RULE7
                tx_first_r <= 1'b0;
                if (tx_last)
                    tx_send_r <= 1'b0; // RULE8
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            txd <= 1'b1;
        else
            txd <= !tx_send_r ? 1'b1
                 : (tx_den_r ? tx_sr_r[0] : 1'b0); // RULE1
    end

    //--------------------------------------------------------------
    // Receiver
    //--------------------------------------------------------------
    logic [8:0] rx_sr_r;
    logic [3:0] rx_cnt_r;
    logic       rx_m1_r, rx_m2_r, rx_m3_r, rx_f_r, rx_fd_r;
    logic       rx_busy_r, rx_first_r, rx_tail_r, s7_r, s8_r;
    logic       rx_edge, rx_smp, rx_bit, rx_final, rx_load;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_m1_r <= 1'b1;
            rx_m2_r <= 1'b1;
            rx_m3_r <= 1'b1;
            rx_f_r  <= 1'b1;
            rx_fd_r <= 1'b1;
        end else begin
            rx_m1_r <= rxd;
            rx_m2_r <= rx_m1_r;
            rx_m3_r <= rx_m2_r;
            if (rx_m2_r == rx_m3_r)
                rx_f_r <= rx_m3_r;
            rx_fd_r <= rx_f_r;
        end
    end

    assign rx_edge  = !rx_busy_r && rx_en_r && rx_fd_r
                   && !rx_f_r; // RULE9
    assign rx_smp   = rx_busy_r && rx_tick && (rx_cnt_r == SMP_C);
    assign rx_bit   = maj3(s7_r, s8_r, rx_f_r); // RULE11
    assign rx_final = rx_smp && !rx_tail_r && !rx_first_r
                   && !rx_sr_r[8]; // RULE13
    assign rx_load  = rx_final && !rx_full_r
                   && (!mpf_r || rx_bit); // RULE14

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_cnt_r <= 4'h0;
            s7_r     <= 1'b1;
            s8_r     <= 1'b1;
        end else if (rx_edge) begin
            rx_cnt_r <= 4'h0; // RULE10
        end else if (rx_tick) begin
            rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_cnt_r == SMP_A)
                s7_r <= rx_f_r; // RULE11
            if (rx_cnt_r == SMP_B)
                s8_r <= rx_f_r; // RULE11
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_sr_r    <= RX_PRELOAD;
            rx_busy_r  <= 1'b0;
            rx_first_r <= 1'b0;
            rx_tail_r  <= 1'b0;
        end else if (rx_edge) begin
            rx_sr_r    <= RX_PRELOAD; // RULE10
            rx_busy_r  <= 1'b1;
            rx_first_r <= 1'b1;
        end else if (rx_smp) begin
            if (rx_tail_r) begin
                rx_busy_r <= 1'b0; // RULE15
                rx_tail_r <= 1'b0;
            end else if (rx_first_r && rx_bit) begin
                rx_busy_r  <= 1'b0; // RULE12
                rx_first_r <= 1'b0;
            end else begin
                rx_sr_r    <= {rx_sr_r[7:0], rx_bit}; // RULE13
                rx_first_r <= 1'b0;
                rx_tail_r  <= rx_final;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buf_r   <= 8'h00;
            rx_ninth_r <= 1'b0;
        end else if (rx_load) begin
            rx_buf_r   <= rev8(rx_sr_r[7:0]); // RULE14
            rx_ninth_r <= rx_bit; // RULE3
        end
    end

    // Hardware set wins over a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_done_r <= 1'b0;
            rx_full_r <= 1'b0;
        end else begin
            if (tx_fin)
                tx_done_r <= 1'b1; // RULE8
            else if (wr_en && hit(paddr, OFS_SERIAL_CONTROL_REG))
                tx_done_r <= pwdata[B_TXDONE];
            if (rx_load)
                rx_full_r <= 1'b1; // RULE14
            else if (wr_en && hit(paddr, OFS_SERIAL_CONTROL_REG))
                rx_full_r <= pwdata[B_RXFULL];
        end
    end

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_tx_idle_high: assert property (!$past(tx_send_r) |-> txd) // RULE1
        else $error("txd low while idle");
    a_tx_start_low: assert property ($rose(tx_send_r) |=> !txd) // RULE6
        else $error("start bit not low");
    a_tx_req_taken: assert property (serial_data_buffer_wr |=> tx_req_r) // RULE4
        else $error("buffer write did not request");
    a_tx_start_roll: assert property (
        $rose(tx_send_r) |-> $past(tx_roll && tx_req_r)) // RULE5
        else $error("transmit not aligned to rollover");
    a_tx_done_end: assert property (
        $fell(tx_send_r) |-> tx_done_r && $past(tx_sr_r[1])) // RULE8
        else $error("done not set at final shift");
    a_tx_stop_in: assert property (
        tx_roll && tx_send_r && tx_first_r |=> tx_sr_r[8]) // RULE7
        else $error("first shift lacks stop bit");
    a_rx_preload: assert property (
        rx_edge |=> rx_sr_r == RX_PRELOAD && rx_cnt_r == 4'h0) // RULE10
        else $error("edge did not preload and clear");
    a_rx_load_cond: assert property (
        rx_load |-> !rx_full_r && (!mpf_r || rx_bit)) // RULE14
        else $error("frame stored against filter");
    a_rx_flag_set: assert property (
        rx_load |=> rx_full_r && rx_ninth_r == $past(rx_bit)) // RULE14
        else $error("stored frame not flagged");
    a_rx_false_start: assert property (
        rx_smp && rx_first_r && rx_bit |=> !rx_busy_r) // RULE12
        else $error("false start not rejected");
    a_t2_no_flag: assert property (
        t2_baud && !wr_en |=> !$rose(t2ovf_flag_r)) // RULE21
        else $error("baud rollover set timer 2 flag");

    c_tx_frame: cover property ($fell(tx_send_r));
    c_rx_store: cover property (rx_load);
    c_rx_drop:  cover property (rx_final && !rx_load);
    c_rx_abort: cover property (rx_smp && rx_first_r && rx_bit);
endmodule

// ==== sim/unbg_node.sv ====
// Remote serial node model facing the nine-bit serial port
`timescale 1ns/1ns
module unbg_node (
    input  wire logic pclk,
    input  wire logic txd,
    output logic      rxd
);
    // ------------------------------------------------------------
    // Line driver and frame sampler
    // ------------------------------------------------------------
    initial rxd = 1'b1;

    // Start, nine bits LSB first, stop; spike inverts mid-bit briefly
    task automatic send(input int bp, input logic [8:0] v, input bit spike);
        logic [10:0] f;
        f = {1'b1, v, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge pclk) rxd <= f[i];
            repeat (bp / 2 - 1) @(posedge pclk);
            if (spike && i < 10) begin
                rxd <= ~f[i];
                repeat (3) @(posedge pclk);
                rxd <= f[i];
                repeat (bp / 2 - 3) @(posedge pclk);
            end else begin
                repeat (bp / 2) @(posedge pclk);
            end
        end
    endtask

    task automatic glitch(input int n);
        @(posedge pclk) rxd <= 1'b0;
        repeat (n) @(posedge pclk);
        rxd <= 1'b1;
    endtask

    // Waits for a start bit, then samples each bit at its middle
    task automatic recv(input int bp, output logic [10:0] f, output bit ok);
        int n;
        n = 0;
        ok = 1'b0;
        f = 11'h000;
        while (txd !== 1'b0 && n < 4 * bp) begin
            @(posedge pclk);
            n++;
        end
        if (n < 4 * bp) begin
            ok = 1'b1;
            repeat (bp / 2) @(posedge pclk);
            for (int i = 0; i < 11; i++) begin
                f[i] = txd;
                if (i < 10) begin
                    repeat (bp) @(posedge pclk);
                end
            end
        end
    endtask
endmodule

// ==== sim/tb_top.sv ====
// Self-checking testbench for the nine-bit serial port
`timescale 1ns/1ns
module tb_top;
    import unbg_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rxd;
    logic        txd;
    logic [31:0] rd;
    logic        serr;
    int          err_total;
    int          tests_run;

    unbg_top #(.AW(8)) unbg_top_i (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .rxd     (rxd),
        .txd     (txd)
    );
    unbg_node unbg_node_i (.pclk(pclk), .txd(txd), .rxd(rxd));

    always #20 pclk = ~pclk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string s, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", s, e, g);
            err_total++;
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        serr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cfg(input logic [7:0] sc, input logic dbl, input logic t2);
        apb(1'b1, OFS_TIMER2_CONTROL_REG, 32'h0000_0000);
        apb(1'b1, OFS_T1, 32'h0001_00FF);
        apb(1'b1, OFS_T2RLD, 32'h0000_FFFE);
        apb(1'b1, OFS_POWER_CONTROL_REG, {24'h00_0000, dbl, 7'h00});
        apb(1'b1, OFS_TIMER2_CONTROL_REG, t2 ? 32'h0000_0034 : 32'h0000_0000);
        apb(1'b1, OFS_SERIAL_CONTROL_REG, {24'h00_0000, sc});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic tx_case(input logic [7:0] sc, input logic dbl,
                           input logic t2, input int bp, input logic [7:0] d);
        logic [10:0] f;
        bit          ok;
        cfg(sc, dbl, t2);
        apb(1'b1, OFS_SERIAL_DATA_BUFFER, {24'h00_0000, d});
        apb(1'b1, OFS_SERIAL_DATA_BUFFER, {24'h00_0000, ~d});
        unbg_node_i.recv(bp, f, ok);
        chk("tx start", 32'h1, {31'h0, ok});
        chk("tx frame", {21'h0, 1'b1, sc[B_TXNINTH], d, 1'b0}, {21'h0, f});
        apb(1'b0, OFS_SERIAL_CONTROL_REG, 32'h0);
        chk("tx done", 32'h1, {31'h0, rd[B_TXDONE]});
        apb(1'b0, OFS_TIMER2_CONTROL_REG, 32'h0);
        chk("t2 flag", 32'h0, {31'h0, rd[B_T2OVF]});
        repeat (bp) @(posedge pclk);
    endtask

    task automatic rx_full_case();
        cfg(8'h10, 1'b0, 1'b0);
        unbg_node_i.send(64, 9'h1C3, 1'b1);
        apb(1'b0, OFS_SERIAL_DATA_BUFFER, 32'h0);
        chk("rx data", 32'h0000_00C3, {24'h0, rd[7:0]});
        apb(1'b0, OFS_SERIAL_CONTROL_REG, 32'h0);
        chk("rx flags", 32'h3, {30'h0, rd[B_RXNINTH], rd[B_RXFULL]});
        unbg_node_i.send(64, 9'h05A, 1'b0);
        apb(1'b0, OFS_SERIAL_DATA_BUFFER, 32'h0);
        chk("rx kept", 32'h0000_00C3, {24'h0, rd[7:0]});
    endtask

    task automatic rx_filter_case();
        cfg(8'h30, 1'b0, 1'b0);
        unbg_node_i.send(64, 9'h0AA, 1'b0);
        unbg_node_i.send(64, 9'h155, 1'b0);
        apb(1'b0, OFS_SERIAL_DATA_BUFFER, 32'h0);
        chk("mp data", 32'h0000_0055, {24'h0, rd[7:0]});
        apb(1'b0, OFS_SERIAL_CONTROL_REG, 32'h0);
        chk("mp flags", 32'h3, {30'h0, rd[B_RXNINTH], rd[B_RXFULL]});
    endtask

    task automatic rx_false_case();
        cfg(8'h50, 1'b0, 1'b1);
        unbg_node_i.glitch(16);
        repeat (192) @(posedge pclk);
        apb(1'b0, OFS_SERIAL_CONTROL_REG, 32'h0);
        chk("false start", 32'h0, {31'h0, rd[B_RXFULL]});
        unbg_node_i.send(64, 9'h0F0, 1'b0);
        apb(1'b0, OFS_SERIAL_DATA_BUFFER, 32'h0);
        chk("m3 rx data", 32'h0000_00F0, {24'h0, rd[7:0]});
        apb(1'b0, OFS_SERIAL_CONTROL_REG, 32'h0);
        chk("m3 rx ninth", 32'h1, {30'h0, rd[B_RXNINTH], rd[B_RXFULL]});
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        err_total = 0;
        tests_run = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        chk("txd idle", 32'h1, {31'h0, txd});
        apb(1'b0, OFS_POWER_CONTROL_REG, 32'h0);
        chk("double rst", 32'h0, {31'h0, rd[B_BDOUBLE]});
        tx_case(8'h18, 1'b0, 1'b0, 64, 8'hA5);
        tx_case(8'h10, 1'b1, 1'b0, 32, 8'h3C);
        tx_case(8'h58, 1'b0, 1'b1, 64, 8'h81);
        tx_case(8'h50, 1'b1, 1'b0, 192, 8'h7E);
        rx_full_case();
        rx_filter_case();
        rx_false_case();
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, serr});
        chk("unmapped data", 32'h0, rd);
        end_of_test();
    end

    initial begin
        repeat (40000) @(posedge pclk);
        err_total++;
        end_of_test();
    end
endmodule
